/* verilog/isf_cfg.svh */
// Overview of operation
// - Master: write busy=1, inhibit=0 issues start.
// - Master: write busy=0, inhibit=0 issues stop.
// - Repeated start uses same write as start.
// - Inhibit reads 1, writing 1 ignored.
// - Status clears on reset and standby.
// - Bits 7..1 clear-only; bit 0 read/write.
// - Slave: stop during frame sets error halt.
// - Error halt clears by write or request clear.
// - Slave: stop after frame sets clean halt.
// - Clean halt clears by write or request clear.
// - Setting frame-done also sets interrupt request.
// - Frame-done set on empty/full, slave needs second hit.
// - After first/general match, frame-done stays clear.
// - Frame-done clears by write or request clear.
// - Slave receive: second address match sets flag.
// - Second hit clears by write or start.
// - First address match shows slave state flags.
// - General call shows both hits, slave receive.
// - Ack reads bus value transmitting, set value receiving.
// - Master transmit: data mismatch at clock rise loses arbitration.
// - Lost, first, general hits clear on data access.
`ifndef ISF_CFG_SVH
`define ISF_CFG_SVH
`define ISF_ADDR_STATUS   12'h000
`define ISF_ADDR_CONTROL  12'h004
`define ISF_ADDR_INTREQ   12'h008
`define ISF_ADDR_DATA     12'h00c
`define ISF_STATUS_RESET  8'h00
`define ISF_CTRL_INHIBIT  0
`define ISF_CTRL_BUSY     1
`define ISF_CTRL_MASTER   2
`define ISF_CTRL_TRANSMIT 3
`define ISF_BIT_ACK       0
`endif

/* verilog/isf_pkg.sv */
package isf_pkg;
  typedef struct packed {
    logic error_halt;
    logic clean_halt;
    logic frame_done;
    logic second_hit;
    logic arb_lost;
    logic primary_hit;
    logic general_hit;
    logic ack;
  } isf_status_s;
  typedef struct packed {
    logic start_cond;
    logic stop_cond;
    logic primary_match;
    logic general_match;
    logic second_match;
    logic data_empty_set;
    logic data_full_set;
    logic frame_active;
    logic ack_in;
  } isf_events_s;
endpackage : isf_pkg

/* verilog/isf_status_flags.sv */
// Local design decisions: the register addresses and register access over APB.
`include "isf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module isf_status_flags (
  input  wire logic               CLK,
  input  wire logic               RESET,
  input  wire logic               STANDBY,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [11:0]        PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire isf_pkg::isf_events_s EVENTS,
  input  wire logic               SCL_IN,
  input  wire logic               SDA_IN,
  input  wire logic               SDA_DRIVEN,
  output logic                    ISSUE_START,
  output logic                    ISSUE_STOP,
  output logic                    MASTER_MODE,
  output logic                    TRANSMIT_MODE,
  output logic                    BUS_BUSY,
  output logic                    INT_REQUEST,
  output logic                    ACK_TO_SEND
);
  import isf_pkg::*;

  isf_status_s st_q;
  isf_status_s st_d;
  isf_status_s seen_q;
  logic        ack_rx_q;
  logic        ack_tx_q;
  logic        master_q;
  logic        transmit_q;
  logic        busy_q;
  logic        intreq_q;
  logic        intreq_seen_q;
  logic        start_q;
  logic        stop_q;
  logic        after_first_q;
  logic        in_slave_rx_q;
  logic [1:0]  scl_sync_q;
  logic [1:0]  sda_sync_q;
  logic        scl_prev_q;
  logic [31:0] prdata_q;

  wire access      = PSEL & PENABLE;
  wire wr          = access & PWRITE;
  wire rd          = access & ~PWRITE;
  wire hit_status  = PADDR == `ISF_ADDR_STATUS;
  wire hit_control = PADDR == `ISF_ADDR_CONTROL;
  wire hit_intreq  = PADDR == `ISF_ADDR_INTREQ;
  wire hit_data    = PADDR == `ISF_ADDR_DATA;
  wire mapped      = hit_status | hit_control | hit_intreq | hit_data;
  wire wr_status   = wr & hit_status;
  wire wr_control  = wr & hit_control;
  wire rd_status   = rd & hit_status;
  wire slave       = ~master_q;
  wire [7:0] wbyte = PWDATA[7:0];

  // A start or stop is only issued when the inhibit bit is written as zero.
  wire issue_en    = wr_control & ~PWDATA[`ISF_CTRL_INHIBIT] & master_q;
  wire start_now   = issue_en & PWDATA[`ISF_CTRL_BUSY];
  wire stop_now    = issue_en & ~PWDATA[`ISF_CTRL_BUSY];

  // Interrupt request clear follows the same read-then-write-zero discipline.
  wire intreq_clr  = wr & hit_intreq & ~PWDATA[0] & intreq_seen_q;
  wire data_access = access & hit_data & (PWRITE == transmit_q);
  wire scl_rise    = scl_sync_q[1] & ~scl_prev_q;
  wire arb_mismatch = master_q & transmit_q & scl_rise & (SDA_DRIVEN != sda_sync_q[1]);
  wire xfer_end    = EVENTS.data_empty_set | EVENTS.data_full_set;
  // Frame-done in slave mode needs the second address hit, and is held off after first or general match.
  wire fd_set      = xfer_end & (master_q | (st_q.second_hit & ~after_first_q));

  // Software clear of a flag: zero written, flag seen as one, not set again since the read.
  wire [7:1] wclr  = {7{wr_status}} & ~wbyte[7:1] & seen_q[7:1];

  always_comb begin
    st_d = st_q;
    st_d.error_halt  = (st_q.error_halt & ~wclr[7] & ~intreq_clr)
                       | (slave & EVENTS.stop_cond & EVENTS.frame_active);
    st_d.clean_halt  = (st_q.clean_halt & ~wclr[6] & ~intreq_clr)
                       | (slave & EVENTS.stop_cond & ~EVENTS.frame_active);
    st_d.frame_done  = (st_q.frame_done & ~wclr[5] & ~intreq_clr) | fd_set;
    st_d.second_hit  = (st_q.second_hit & ~wclr[4] & ~EVENTS.start_cond & ~master_q)
                       | (slave & in_slave_rx_q & EVENTS.second_match);
    st_d.arb_lost    = (st_q.arb_lost & ~wclr[3] & ~data_access) | arb_mismatch;
    st_d.primary_hit = (st_q.primary_hit & ~wclr[2] & ~data_access & ~master_q)
                       | (slave & (EVENTS.primary_match | EVENTS.general_match));
    st_d.general_hit = (st_q.general_hit & ~wclr[1] & ~data_access & ~master_q)
                       | (slave & EVENTS.general_match);
    st_d.ack         = transmit_q ? ack_rx_q : ack_tx_q;
  end

  always_ff @(posedge CLK) begin
    if (RESET | STANDBY) begin
      st_q          <= `ISF_STATUS_RESET;
      seen_q        <= `ISF_STATUS_RESET;
      ack_rx_q      <= 1'b0;
      ack_tx_q      <= 1'b0;
      intreq_q      <= 1'b0;
      intreq_seen_q <= 1'b0;
      after_first_q <= 1'b0;
    end else begin
      st_q          <= st_d;
      // A bit set after the read must not be clearable by the following write.
      seen_q        <= rd_status ? st_q : (seen_q & st_q & ~(st_d & ~st_q));
      if (transmit_q & EVENTS.frame_active == 1'b0 & xfer_end)
        ack_rx_q <= EVENTS.ack_in;
      if (wr_status)
        ack_tx_q <= wbyte[`ISF_BIT_ACK];
      intreq_q      <= (intreq_q & ~intreq_clr) | fd_set | xfer_end
                       | (slave & (EVENTS.stop_cond | EVENTS.primary_match
                       | EVENTS.general_match | EVENTS.second_match));
      intreq_seen_q <= (rd & hit_intreq) ? intreq_q : (intreq_seen_q & intreq_q & ~intreq_clr);
      if (EVENTS.start_cond | EVENTS.stop_cond)
        after_first_q <= 1'b0;
      else if (slave & (EVENTS.primary_match | EVENTS.general_match))
        after_first_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      master_q      <= 1'b0;
      transmit_q    <= 1'b0;
      busy_q        <= 1'b0;
      in_slave_rx_q <= 1'b0;
      start_q       <= 1'b0;
      stop_q        <= 1'b0;
      scl_sync_q    <= 2'h3;
      sda_sync_q    <= 2'h3;
      scl_prev_q    <= 1'b1;
      prdata_q      <= 32'h0000_0000;
    end else begin
      scl_sync_q    <= {scl_sync_q[0], SCL_IN};
      sda_sync_q    <= {sda_sync_q[0], SDA_IN};
      scl_prev_q    <= scl_sync_q[1];
      start_q       <= start_now;
      stop_q        <= stop_now;
      if (wr_control) begin
        master_q   <= PWDATA[`ISF_CTRL_MASTER];
        transmit_q <= PWDATA[`ISF_CTRL_TRANSMIT];
      end else if (arb_mismatch) begin
        master_q   <= 1'b0;
        transmit_q <= 1'b0;
      end else if (slave & (EVENTS.primary_match | EVENTS.general_match)) begin
        transmit_q <= 1'b0;
      end
      if (EVENTS.start_cond)
        busy_q <= 1'b1;
      else if (EVENTS.stop_cond)
        busy_q <= 1'b0;
      if (EVENTS.start_cond)
        in_slave_rx_q <= slave;
      else if (EVENTS.second_match | EVENTS.primary_match | EVENTS.general_match)
        in_slave_rx_q <= 1'b0;
      if (rd)
        prdata_q <= hit_status  ? {24'h00_0000, st_q} :
                    hit_control ? {28'h000_0000, transmit_q, master_q, busy_q, 1'b1} :
                    hit_intreq  ? {31'h0000_0000, intreq_q} : 32'h0000_0000;
    end
  end

  // The slave never stalls, so read data is driven combinationally in the access cycle itself.
  assign PREADY        = 1'b1;
  assign PSLVERR       = access & ~mapped;
  assign PRDATA        = rd ? (hit_status  ? {24'h00_0000, st_q} :
                               hit_control ? {28'h000_0000, transmit_q, master_q, busy_q, 1'b1} :
                               hit_intreq  ? {31'h0000_0000, intreq_q} : 32'h0000_0000) : prdata_q;
  assign ISSUE_START   = start_q;
  assign ISSUE_STOP    = stop_q;
  assign MASTER_MODE   = master_q;
  assign TRANSMIT_MODE = transmit_q;
  assign BUS_BUSY      = busy_q;
  assign INT_REQUEST   = intreq_q;
  assign ACK_TO_SEND   = ack_tx_q;
endmodule : isf_status_flags
`default_nettype wire

/* tb/isf_bus_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module isf_bus_peer (
  input  wire logic go,
  output logic      scl,
  output logic      sda
);
  // Lines rest high on their pull-ups, and the clock runs only inside a frame.
  initial begin
    scl = 1'h1;
    sda = 1'h1;
    forever begin
      @(posedge go);
      sda = 1'h0;
      repeat (9) begin
        #40 scl = 1'h0;
        #40 scl = 1'h1;
      end
      #40 sda = 1'h1;
    end
  end
endmodule : isf_bus_peer
`default_nettype wire

/* tb/isf_sf_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module isf_sf_chk (
  input wire logic                  CLK,
  input wire logic                  RESET,
  input wire logic                  STANDBY,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PWRITE,
  input wire logic [11:0]           PADDR,
  input wire logic [31:0]           PWDATA,
  input wire logic [31:0]           PRDATA,
  input wire isf_pkg::isf_events_s  EVENTS,
  input wire logic                  ISSUE_START,
  input wire logic                  ISSUE_STOP,
  input wire logic                  MASTER_MODE,
  input wire logic                  INT_REQUEST,
  input wire logic                  ACK_TO_SEND
);
  import isf_pkg::*;
  wire acc  = PSEL && PENABLE;
  wire wr_c = acc && PWRITE && PADDR == 12'h004;
  wire wr_s = acc && PWRITE && PADDR == 12'h000;
  wire ends = EVENTS.data_empty_set || EVENTS.data_full_set;
  wire wd0  = PWDATA[0];
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  a_start_out: assert property (wr_c && PWDATA[1:0] == 2'h2 && MASTER_MODE |=> ISSUE_START) else $error("no start");
  a_stop_out: assert property (wr_c && PWDATA[1:0] == 2'h0 && MASTER_MODE |=> ISSUE_STOP) else $error("no stop");
  a_inhibit_hold: assert property (wr_c && wd0 |=> !ISSUE_START && !ISSUE_STOP) else $error("issued");
  a_inhibit_read: assert property (acc && !PWRITE && PADDR == 12'h004 |-> PRDATA[0]) else $error("bit 0");
  a_standby_clr: assert property (STANDBY && EVENTS == '0 |=> !INT_REQUEST) else $error("standby");
  a_ack_written: assert property (wr_s |=> ACK_TO_SEND == $past(wd0)) else $error("ack");
  a_frame_int: assert property (MASTER_MODE && ends |=> INT_REQUEST) else $error("frame irq");
  a_slave_stop: assert property (!MASTER_MODE && EVENTS.stop_cond |=> INT_REQUEST) else $error("stop irq");
  c_start: cover property (wr_c && MASTER_MODE);
  c_err_stop: cover property (EVENTS.stop_cond && EVENTS.frame_active);
  c_standby: cover property (STANDBY);
endmodule : isf_sf_chk
bind isf_status_flags isf_sf_chk isf_sf_chk_inst (.*);
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import isf_pkg::*;
  logic CLK, RESET, STANDBY, PSEL, PENABLE, PWRITE, SDA_DRIVEN, go, err, PREADY, PSLVERR;
  logic ISSUE_START, ISSUE_STOP, MASTER_MODE, TRANSMIT_MODE, BUS_BUSY, INT_REQUEST, ACK_TO_SEND;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  wire SCL_IN, SDA_IN;
  isf_events_s EVENTS;
  int errors, n_checks, n_start, n_stop, cyc;
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; $display("wrong value %s exp %0h got %0h", n, e, s); end end
  isf_status_flags isf_status_flags_inst (.*);
  isf_bus_peer isf_bus_peer_inst (.go(go), .scl(SCL_IN), .sda(SDA_IN));
  initial begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    n_start <= n_start + (ISSUE_START === 1'h1);
    n_stop <= n_stop + (ISSUE_STOP === 1'h1);
    if (cyc == 5000) begin
      errors++;
      give_verdict();
    end
  end
  // The idle edge at the end keeps back-to-back calls from driving PSEL twice in one step.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK) PENABLE <= 1'h1;
    do @(posedge CLK); while (PREADY !== 1'h1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge CLK);
  endtask : apb
  task st(input logic [7:0] e);
    apb(1'h0, 12'h000, 32'h0);
    `CHK("status", e, rd[7:0])
  endtask : st
  task pulse(input logic [8:0] e);
    EVENTS <= e;
    @(posedge CLK) EVENTS <= '0;
    @(posedge CLK);
  endtask : pulse
  task t_master;
    apb(1'h0, 12'h004, 32'h0);
    `CHK("inhibit", 1'h1, rd[0])
    apb(1'h0, 12'h010, 32'h0);
    `CHK("slverr", 1'h1, err)
    apb(1'h1, 12'h004, 32'h0d);
    apb(1'h1, 12'h004, 32'h0e);
    apb(1'h1, 12'h004, 32'h0e);
    apb(1'h1, 12'h004, 32'h0f);
    apb(1'h1, 12'h004, 32'h0c);
    @(posedge CLK);
    `CHK("starts", 2, n_start)
    `CHK("stops", 1, n_stop)
    SDA_DRIVEN <= 1'h1;
    go <= 1'h1;
    repeat (100) @(posedge CLK);
    go <= 1'h0;
    st(8'h08);
    apb(1'h0, 12'h00c, 32'h0);
    st(8'h00);
    apb(1'h1, 12'h004, 32'h05);
    pulse(9'h008);
    st(8'h20);
    `CHK("irq", 1'h1, INT_REQUEST)
    apb(1'h0, 12'h008, 32'h0);
    apb(1'h1, 12'h008, 32'h0);
    st(8'h00);
  endtask : t_master
  task t_slave;
    apb(1'h1, 12'h004, 32'h01);
    pulse(9'h082);
    st(8'h80);
    apb(1'h0, 12'h008, 32'h0);
    apb(1'h1, 12'h008, 32'h0);
    st(8'h00);
    pulse(9'h080);
    st(8'h40);
    apb(1'h1, 12'h000, 32'h0);
    st(8'h00);
    pulse(9'h100);
    pulse(9'h010);
    st(8'h10);
    pulse(9'h004);
    apb(1'h1, 12'h000, 32'h0);
    st(8'h20);
    pulse(9'h100);
    pulse(9'h010);
    pulse(9'h100);
    st(8'h20);
    apb(1'h0, 12'h008, 32'h0);
    apb(1'h1, 12'h008, 32'h0);
    pulse(9'h040);
    st(8'h04);
    `CHK("busy", 1'h1, BUS_BUSY)
    pulse(9'h004);
    st(8'h04);
    apb(1'h0, 12'h00c, 32'h0);
    st(8'h00);
    pulse(9'h020);
    st(8'h06);
    apb(1'h1, 12'h000, 32'h07);
    st(8'h07);
    STANDBY <= 1'h1;
    @(posedge CLK) STANDBY <= 1'h0;
    @(posedge CLK);
    st(8'h00);
  endtask : t_slave
  initial begin
    {RESET, STANDBY, PSEL, PENABLE, PWRITE, SDA_DRIVEN, go} = 7'h40;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    EVENTS = '0;
    repeat (16) @(posedge CLK);
    RESET <= 1'h0;
    st(8'h00);
    t_master();
    t_slave();
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
